// ### plm_monitor.v
// What this block does
// - dual-modulus feedback divides the oscillator clock by P times B plus A
// - fixed-divide mode ignores A, ratio is P times B
// - mode combinations and B bypass reach every ratio down to one
// - two-bit field sets antibacklash width, zero gives about 1.3 ns
// - four-bit selector picks the signal driven on the status pin
// - digital lock on status pin is push-pull, polarity set by code
// - wide window: lock within 9.5 ns, unlock at 15 ns or more
// - narrow window: lock within 3.5 ns, unlock at 7 ns or more
// - lock disable bit turns the digital lock detector off
// - code 1100 analog lock as P open-drain, 0101 as N open-drain
// - analog lock true apart from false pulses growing with separation
// - code 1010 reference-lost high, 1111 reference-lost low
// - reference monitor advances on oscillator edges only
// - digital lock clears after reference loss once an unpaired feedback edge reaches the unlock limit
// - code 1101 not-lock OR reference-lost high, 1110 same low
// - monitor arms after lock holds 3 to 24 comparator cycles by field
// - armed monitor on missing reference sets flag and tristates pump
// - clearing enable releases pump and flag, setting it re-arms
// - two-bit field picks control pin role, open pin means reset
// - role 00 reset, 01 output align, 11 power-down, all low active
`timescale 1ns/1ps
`default_nettype none
`include "plm_map.vh"

module plm_monitor (
  input wire clk,
  input wire rst_b,
  input wire reference_clock_input,
  input wire vcoIn,
  input wire functionPin,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrEn,
  output reg [7:0] regRdData,
  output reg statusOut,
  output reg statusOe,
  output wire pumpUp,
  output wire pumpDown,
  output wire pumpTristate,
  output wire digitalLock,
  output reg feedbackPulse,
  output wire hardResetActive,
  output wire outputAlignActive,
  output wire powerDownActive
);
  // pin synchronisers
  reg refMeta;
  reg refSync;
  reg refLast;
  reg vcoMeta;
  reg vcoSync;
  reg vcoLast;
  reg pinMeta;
  reg pinSync;

  always @(posedge clk) begin
    if (!rst_b) begin
      refMeta <= 1'b0;
      refSync <= 1'b0;
      refLast <= 1'b0;
      vcoMeta <= 1'b0;
      vcoSync <= 1'b0;
      vcoLast <= 1'b0;
      pinMeta <= 1'b0;
      pinSync <= 1'b0;
    end else begin
      refMeta <= reference_clock_input;
      refSync <= refMeta;
      refLast <= refSync;
      vcoMeta <= vcoIn;
      vcoSync <= vcoMeta;
      vcoLast <= vcoSync;
      pinMeta <= functionPin;
      pinSync <= pinMeta;
    end
  end

  wire refEdge = refSync & ~refLast;
  wire vcoEdge = vcoSync & ~vcoLast;

  // registers
  reg [5:0] aCount;
  reg [12:0] bCount;
  reg lossEnable;
  reg [1:0] armDelaySel;
  reg [3:0] statusSel;
  reg [2:0] prescCode;
  reg bBypass;
  reg [1:0] ablSel;
  reg windowNarrow;
  reg lockDisable;
  reg [1:0] pinRole;

  // a low pin in reset role reloads the defaults; the pin reads low when open
  wire pinLow = ~pinSync;
  wire pinReset = (pinRole == `PLM_ROLE_RESET) && pinLow;
  wire coreRst_b = rst_b & ~pinReset;

  assign hardResetActive = pinReset;
  assign outputAlignActive = (pinRole == `PLM_ROLE_ALIGN) && pinLow;
  assign powerDownActive = (pinRole == `PLM_ROLE_PDOWN) && pinLow;

  always @(posedge clk) begin
    if (!coreRst_b) begin
      aCount <= `PLM_RST_ACNT;
      bCount <= `PLM_RST_BCNT;
      lossEnable <= `PLM_RST_LOSS_EN;
      armDelaySel <= `PLM_RST_LOSS_DLY;
      statusSel <= `PLM_RST_STAT_SEL;
      prescCode <= `PLM_RST_PRESC;
      bBypass <= 1'b0;
      ablSel <= `PLM_RST_ABL;
      windowNarrow <= 1'b0;
      lockDisable <= 1'b0;
      pinRole <= `PLM_RST_ROLE;
    end else if (regWrEn) begin
      case (regAddr)
        `PLM_REG_ACNT: begin
          aCount <= regWrData[5:0];
        end
        `PLM_REG_BLO: begin
          bCount[7:0] <= regWrData;
        end
        `PLM_REG_BHI: begin
          bCount[12:8] <= regWrData[4:0];
        end
        `PLM_REG_LOSS: begin
          lossEnable <= regWrData[`PLM_LOSS_EN_BIT];
          armDelaySel <= regWrData[`PLM_LOSS_DLY_HI:`PLM_LOSS_DLY_LO];
        end
        `PLM_REG_STAT: begin
          statusSel <= regWrData[`PLM_STAT_SEL_HI:`PLM_STAT_SEL_LO];
        end
        `PLM_REG_PRESC: begin
          prescCode <= regWrData[`PLM_PRESC_HI:`PLM_PRESC_LO];
          bBypass <= regWrData[`PLM_BBYP_BIT];
        end
        `PLM_REG_LOCK: begin
          ablSel <= regWrData[`PLM_ABL_HI:`PLM_ABL_LO];
          windowNarrow <= regWrData[`PLM_WIN_BIT];
          lockDisable <= regWrData[`PLM_LDOFF_BIT];
        end
        `PLM_REG_ROLE: begin
          pinRole <= regWrData[`PLM_ROLE_HI:`PLM_ROLE_LO];
        end
        default: begin
        end
      endcase
    end
  end

  // feedback ratio
  function [18:0] feedbackRatio;
    input [2:0] code;
    input [5:0] a;
    input [12:0] b;
    input bypass;
    reg [18:0] pv;
    reg [18:0] bv;
    reg [18:0] prod;
    reg dm;
    begin
      dm = 1'b1;
      case (code)
        `PLM_PS_FD1: begin
          pv = 19'd1;
          dm = 1'b0;
        end
        `PLM_PS_FD2: begin
          pv = 19'd2;
          dm = 1'b0;
        end
        `PLM_PS_FD3: begin
          pv = 19'd3;
          dm = 1'b0;
        end
        `PLM_PS_DM2: pv = 19'd2;
        `PLM_PS_DM4: pv = 19'd4;
        `PLM_PS_DM8: pv = 19'd8;
        `PLM_PS_DM16: pv = 19'd16;
        default: pv = 19'd32;
      endcase
      // bypass only counts in fixed-divide mode
      bv = (bypass && !dm) ? 19'd1 : {6'h00, b};
      prod = pv * bv;
      if (dm) begin
        prod = prod + {13'h0000, a};
      end
      // a zero ratio is invalid; fall back to one instead of stalling
      feedbackRatio = (prod == 19'd0) ? 19'd1 : prod;
    end
  endfunction

  wire [18:0] ratio = feedbackRatio(prescCode, aCount, bCount, bBypass);
  reg [18:0] fbCount;

  always @(posedge clk) begin
    if (!coreRst_b) begin
      fbCount <= 19'd0;
      feedbackPulse <= 1'b0;
    end else if (vcoEdge) begin
      if (fbCount >= ratio - 19'd1) begin
        fbCount <= 19'd0;
        feedbackPulse <= 1'b1;
      end else begin
        fbCount <= fbCount + 19'd1;
        feedbackPulse <= 1'b0;
      end
    end else begin
      feedbackPulse <= 1'b0;
    end
  end

  wire rawUp;
  wire rawDown;
  wire analogLock;

  plm_phase_lock phaseLock (
    .clk(clk),
    .rst_b(coreRst_b),
    .refEdge(refEdge),
    .fbEdge(feedbackPulse),
    .ablSel(ablSel),
    .windowNarrow(windowNarrow),
    .lockDisable(lockDisable),
    .pumpUp(rawUp),
    .pumpDown(rawDown),
    .analogLock(analogLock),
    .digitalLock(digitalLock)
  );

  // reference-loss monitor
  function [4:0] armTarget;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: armTarget = `PLM_ARM_D0;
        2'h1: armTarget = `PLM_ARM_D1;
        2'h2: armTarget = `PLM_ARM_D2;
        default: armTarget = `PLM_ARM_D3;
      endcase
    end
  endfunction

  reg [4:0] armCount;
  reg armed;
  reg refLost;
  reg [19:0] vcoSinceRef;
  // two comparator periods of oscillator edges without a reference edge
  wire [19:0] lossLimit = {ratio, 1'b0};

  always @(posedge clk) begin
    if (!coreRst_b || !lossEnable) begin
      armCount <= 5'd0;
      armed <= 1'b0;
      refLost <= 1'b0;
      vcoSinceRef <= 20'd0;
    end else begin
      if (!armed) begin
        if (!digitalLock) begin
          armCount <= 5'd0;
        end else if (feedbackPulse) begin
          if (armCount + 5'd1 >= armTarget(armDelaySel)) begin
            armed <= 1'b1;
          end
          armCount <= armCount + 5'd1;
        end
      end
      if (refEdge) begin
        vcoSinceRef <= 20'd0;
      end else if (vcoEdge) begin
        if (vcoSinceRef < lossLimit) begin
          vcoSinceRef <= vcoSinceRef + 20'd1;
        end else if (armed) begin
          refLost <= 1'b1;
        end
      end
    end
  end

  // lock clears only once an unpaired feedback edge reaches the unlock limit, so pump gating uses refLost
  assign pumpTristate = refLost;
  assign pumpUp = rawUp & ~refLost;
  assign pumpDown = rawDown & ~refLost;

  // status pin multiplexer
  wire lossOrUnlock = ~digitalLock | refLost;

  always @(posedge clk) begin
    if (!coreRst_b) begin
      statusOut <= 1'b0;
      statusOe <= 1'b1;
    end else begin
      case (statusSel)
        `PLM_SEL_DLD_HIGH: begin
          statusOut <= digitalLock;
          statusOe <= 1'b1;
        end
        `PLM_SEL_DLD_LOW: begin
          statusOut <= ~digitalLock;
          statusOe <= 1'b1;
        end
        `PLM_SEL_ALD_PCH: begin
          statusOut <= 1'b1;
          statusOe <= analogLock;
        end
        `PLM_SEL_ALD_NCH: begin
          statusOut <= 1'b0;
          statusOe <= ~analogLock;
        end
        `PLM_SEL_REFERENCE_LOST_FLAG_HIGH: begin
          statusOut <= refLost;
          statusOe <= 1'b1;
        end
        `PLM_SEL_REFERENCE_LOST_FLAG_LOW: begin
          statusOut <= ~refLost;
          statusOe <= 1'b1;
        end
        `PLM_SEL_COMB_HIGH: begin
          statusOut <= lossOrUnlock;
          statusOe <= 1'b1;
        end
        `PLM_SEL_COMB_LOW: begin
          statusOut <= ~lossOrUnlock;
          statusOe <= 1'b1;
        end
        default: begin
          statusOut <= 1'b0;
          statusOe <= 1'b1;
        end
      endcase
    end
  end

  // register readback; reserved bits read zero
  always @(posedge clk) begin
    if (!coreRst_b) begin
      regRdData <= 8'h00;
    end else begin
      case (regAddr)
        `PLM_REG_ACNT: regRdData <= {2'h0, aCount};
        `PLM_REG_BLO: regRdData <= bCount[7:0];
        `PLM_REG_BHI: regRdData <= {3'h0, bCount[12:8]};
        `PLM_REG_LOSS: regRdData <= {1'b0, armDelaySel, refLost, armed, lossEnable, 2'h0};
        `PLM_REG_STAT: regRdData <= {2'h0, statusSel, 2'h0};
        `PLM_REG_PRESC: regRdData <= {1'b0, bBypass, 1'b0, prescCode, 2'h0};
        `PLM_REG_LOCK: regRdData <= {digitalLock, lockDisable, windowNarrow, 3'h0, ablSel};
        `PLM_REG_ROLE: regRdData <= {1'b0, pinRole, 5'h00};
        default: regRdData <= 8'h00;
      endcase
    end
  end
endmodule // plm_monitor

`default_nettype wire

// ### plm_map.vh
`ifndef PLM_MAP_VH
`define PLM_MAP_VH

// register offsets
`define PLM_REG_ACNT 8'h04
`define PLM_REG_BLO 8'h05
`define PLM_REG_BHI 8'h06
`define PLM_REG_LOSS 8'h07
`define PLM_REG_STAT 8'h08
`define PLM_REG_PRESC 8'h0a
`define PLM_REG_LOCK 8'h0d
`define PLM_REG_ROLE 8'h58

// field positions
`define PLM_LOSS_EN_BIT 2
`define PLM_LOSS_DLY_HI 6
`define PLM_LOSS_DLY_LO 5
`define PLM_STAT_SEL_HI 5
`define PLM_STAT_SEL_LO 2
`define PLM_PRESC_HI 4
`define PLM_PRESC_LO 2
`define PLM_BBYP_BIT 6
`define PLM_ABL_HI 1
`define PLM_ABL_LO 0
`define PLM_WIN_BIT 5
`define PLM_LDOFF_BIT 6
`define PLM_ROLE_HI 6
`define PLM_ROLE_LO 5

// reset values
`define PLM_RST_ACNT 6'h00
`define PLM_RST_BCNT 13'h0000
`define PLM_RST_LOSS_EN 1'b0
`define PLM_RST_LOSS_DLY 2'h0
`define PLM_RST_STAT_SEL 4'h0
`define PLM_RST_PRESC 3'h0
`define PLM_RST_ABL 2'h0
`define PLM_RST_ROLE 2'h0

// status selector codes
`define PLM_SEL_DLD_HIGH 4'h1
`define PLM_SEL_DLD_LOW 4'h3
`define PLM_SEL_ALD_NCH 4'h5
`define PLM_SEL_REFERENCE_LOST_FLAG_HIGH 4'ha
`define PLM_SEL_ALD_PCH 4'hc
`define PLM_SEL_COMB_HIGH 4'hd
`define PLM_SEL_COMB_LOW 4'he
`define PLM_SEL_REFERENCE_LOST_FLAG_LOW 4'hf

// control pin roles
`define PLM_ROLE_RESET 2'h0
`define PLM_ROLE_ALIGN 2'h1
`define PLM_ROLE_PDOWN 2'h3

// prescaler codes
`define PLM_PS_FD1 3'h0
`define PLM_PS_FD2 3'h1
`define PLM_PS_DM2 3'h2
`define PLM_PS_DM4 3'h3
`define PLM_PS_DM8 3'h4
`define PLM_PS_DM16 3'h5
`define PLM_PS_DM32 3'h6
`define PLM_PS_FD3 3'h7

// timing, picoseconds
`define PLM_CLK_PS 5000
`define PLM_WIDE_ON_PS 9500
`define PLM_WIDE_OFF_PS 15000
`define PLM_NARROW_ON_PS 3500
`define PLM_NARROW_OFF_PS 7000
`define PLM_ABL0_PS 1300
`define PLM_ABL1_PS 2500
`define PLM_ABL2_PS 5000
`define PLM_ABL3_PS 10000

// arm delays in phase comparator cycles
`define PLM_ARM_D0 5'd3
`define PLM_ARM_D1 5'd6
`define PLM_ARM_D2 5'd12
`define PLM_ARM_D3 5'd24

`endif

// ### plm_phase_lock.v
`timescale 1ns/1ps
`default_nettype none
`include "plm_map.vh"

module plm_phase_lock (
  input wire clk,
  input wire rst_b,
  input wire refEdge,
  input wire fbEdge,
  input wire [1:0] ablSel,
  input wire windowNarrow,
  input wire lockDisable,
  output reg pumpUp,
  output reg pumpDown,
  output reg analogLock,
  output reg digitalLock
);
  // least times round down, longest times round up, never below one cycle
  localparam integer WIDE_ON_RAW = `PLM_WIDE_ON_PS / `PLM_CLK_PS;
  localparam integer NARROW_ON_RAW = `PLM_NARROW_ON_PS / `PLM_CLK_PS;
  localparam [3:0] WIDE_ON = (WIDE_ON_RAW < 1) ? 4'd1 : WIDE_ON_RAW[3:0];
  localparam [3:0] NARROW_ON = (NARROW_ON_RAW < 1) ? 4'd1 : NARROW_ON_RAW[3:0];
  localparam integer WIDE_OFF_RAW = (`PLM_WIDE_OFF_PS + `PLM_CLK_PS - 1) / `PLM_CLK_PS;
  localparam integer NARROW_OFF_RAW = (`PLM_NARROW_OFF_PS + `PLM_CLK_PS - 1) / `PLM_CLK_PS;
  localparam [3:0] WIDE_OFF = WIDE_OFF_RAW[3:0];
  localparam [3:0] NARROW_OFF = NARROW_OFF_RAW[3:0];

  function [3:0] ablCycles;
    input [1:0] sel;
    integer ps;
    begin
      case (sel)
        2'h0: ps = `PLM_ABL0_PS;
        2'h1: ps = `PLM_ABL1_PS;
        2'h2: ps = `PLM_ABL2_PS;
        default: ps = `PLM_ABL3_PS;
      endcase
      ps = (ps + `PLM_CLK_PS - 1) / `PLM_CLK_PS;
      ablCycles = (ps < 1) ? 4'd1 : ps[3:0];
    end
  endfunction

  wire [3:0] onLimit = windowNarrow ? NARROW_ON : WIDE_ON;
  wire [3:0] offLimit = windowNarrow ? NARROW_OFF : WIDE_OFF;
  wire [3:0] ablWidth = ablCycles(ablSel);

  reg [3:0] ablCount;
  reg refPend;
  reg fbPend;
  reg [3:0] sepCount;
  wire refAny = refEdge | refPend;
  wire fbAny = fbEdge | fbPend;

  // comparator with antibacklash overlap
  always @(posedge clk) begin
    if (!rst_b) begin
      pumpUp <= 1'b0;
      pumpDown <= 1'b0;
      ablCount <= 4'h0;
    end else if (pumpUp && pumpDown) begin
      if (ablCount >= ablWidth - 4'h1) begin
        pumpUp <= refEdge;
        pumpDown <= fbEdge;
        ablCount <= 4'h0;
      end else begin
        ablCount <= ablCount + 4'h1;
      end
    end else begin
      pumpUp <= pumpUp | refEdge;
      pumpDown <= pumpDown | fbEdge;
      ablCount <= 4'h0;
    end
  end

  // false pulse lasts while only one side is active, so it widens with separation
  always @(posedge clk) begin
    if (!rst_b) begin
      analogLock <= 1'b1;
    end else begin
      analogLock <= ~(pumpUp ^ pumpDown);
    end
  end

  // window measurement with hysteresis between the two limits
  always @(posedge clk) begin
    if (!rst_b || lockDisable) begin
      digitalLock <= 1'b0;
      refPend <= 1'b0;
      fbPend <= 1'b0;
      sepCount <= 4'h0;
    end else if (refAny && fbAny) begin
      if ((refEdge && fbEdge && !refPend && !fbPend) || sepCount <= onLimit) begin
        digitalLock <= 1'b1;
      end else if (sepCount >= offLimit) begin
        digitalLock <= 1'b0;
      end
      refPend <= 1'b0;
      fbPend <= 1'b0;
      sepCount <= 4'h0;
    end else if (refAny || fbAny) begin
      if (sepCount >= offLimit) begin
        digitalLock <= 1'b0;
        refPend <= 1'b0;
        fbPend <= 1'b0;
        sepCount <= 4'h0;
      end else begin
        refPend <= refAny;
        fbPend <= fbAny;
        sepCount <= sepCount + 4'h1;
      end
    end
  end
endmodule // plm_phase_lock

`default_nettype wire

// ### plm_monitor_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "plm_map.vh"
module plm_monitor_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic statusOut,
  input wire logic statusOe,
  input wire logic pumpUp,
  input wire logic pumpDown,
  input wire logic pumpTristate,
  input wire logic digitalLock,
  input wire logic feedbackPulse,
  input wire logic hardResetActive,
  input wire logic outputAlignActive,
  input wire logic powerDownActive
);
  // shadows of written fields; a pin reset clears them as it clears the block
  logic [3:0] sel;
  logic [1:0] role;
  logic [1:0] abl;
  logic en;
  logic ldOff;
  always @(posedge clk) begin
    if (!rst_b || hardResetActive) begin
      sel <= 4'h0;
      role <= 2'h0;
      abl <= 2'h0;
      en <= 1'b0;
      ldOff <= 1'b0;
    end else if (regWrEn) begin
      if (regAddr == `PLM_REG_STAT) sel <= regWrData[5:2];
      if (regAddr == `PLM_REG_ROLE) role <= regWrData[6:5];
      if (regAddr == `PLM_REG_LOCK) abl <= regWrData[1:0];
      if (regAddr == `PLM_REG_LOCK) ldOff <= regWrData[6];
      if (regAddr == `PLM_REG_LOSS) en <= regWrData[2];
    end
  end
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_b || hardResetActive);
  sequence disarm_s;
    en ##1 !en;
  endsequence
  sequence both_on_s;
    abl != 2'h3 && pumpUp && pumpDown;
  endsequence
  fb_pulse_short_a: assert property (feedbackPulse |=> !feedbackPulse)
    else $error("feedback pulse too long");
  abl_width_a: assert property (both_on_s |=> !(pumpUp && pumpDown))
    else $error("antibacklash overlap too long");
  lock_high_pin_a: assert property (sel == `PLM_SEL_DLD_HIGH |=>
    statusOut == $past(digitalLock) && statusOe) else $error("lock high pin wrong");
  lock_low_pin_a: assert property (sel == `PLM_SEL_DLD_LOW |=>
    statusOut == !$past(digitalLock) && statusOe) else $error("lock low pin wrong");
  lock_off_a: assert property (ldOff |=> !digitalLock)
    else $error("lock flag while disabled");
  ald_drain_a: assert property (sel == `PLM_SEL_ALD_NCH || sel == `PLM_SEL_ALD_PCH |=>
    statusOut == $past(sel[3])) else $error("open drain level wrong");
  lost_pin_a: assert property (sel == `PLM_SEL_REFERENCE_LOST_FLAG_HIGH |=>
    statusOut == $past(pumpTristate)) else $error("lost pin wrong");
  comb_pin_a: assert property (sel == `PLM_SEL_COMB_HIGH |=>
    statusOut == (!$past(digitalLock) || $past(pumpTristate))) else $error("combined pin wrong");
  pump_quiet_a: assert property (pumpTristate |-> !pumpUp && !pumpDown)
    else $error("pump drives while lost");
  disarm_clear_a: assert property (disarm_s |=> !pumpTristate [*2])
    else $error("disable left pump off");
  role_pins_a: assert property (outputAlignActive || powerDownActive |->
    role == {powerDownActive, 1'b1} && !hardResetActive) else $error("pin role wrong");
endmodule // plm_monitor_chk
bind plm_monitor plm_monitor_chk i_plm_monitor_chk (
  .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
  .statusOut(statusOut), .statusOe(statusOe), .pumpUp(pumpUp), .pumpDown(pumpDown),
  .pumpTristate(pumpTristate), .digitalLock(digitalLock), .feedbackPulse(feedbackPulse),
  .hardResetActive(hardResetActive), .outputAlignActive(outputAlignActive),
  .powerDownActive(powerDownActive)
);
`default_nettype wire

// ### plm_ref_vco_model.sv
`timescale 1ns/1ps
`default_nettype none
module plm_ref_vco_model (
  input wire logic refEnable,
  input wire logic [15:0] refDivide,
  input wire logic [7:0] refDelay,
  output logic reference_clock_input,
  output logic vcoIn
);
  int count;
  // oscillator runs free; the 1 ns offset keeps its edges off the sampling edge
  initial begin
    vcoIn = 1'b0;
    reference_clock_input = 1'b0;
    count = 0;
    #1;
    forever #20 vcoIn = ~vcoIn;
  end
  // one reference edge per refDivide oscillator cycles; disabled means a dead line
  always @(posedge vcoIn) begin
    count = count + 1;
    if (count >= refDivide && refEnable) begin
      count = 0;
      reference_clock_input <= #(refDelay) 1'b1;
      reference_clock_input <= #(refDelay + 10) 1'b0;
    end
  end
endmodule // plm_ref_vco_model
`default_nettype wire

// ### plm_monitor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "plm_map.vh"
module plm_monitor_tb_top;
  logic clk;
  logic rst_b;
  logic functionPin;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic regWrEn;
  logic refEnable;
  logic [15:0] refDivide;
  logic [7:0] refDelay;
  wire reference_clock_input, vcoIn, statusOut, statusOe, pumpUp, pumpDown, pumpTristate;
  wire digitalLock, feedbackPulse, hardResetActive, outputAlignActive, powerDownActive;
  wire [7:0] regRdData;
  int failures = 0;
  int total_checks = 0;
  int vcoCount = 0;
  plm_monitor i_plm_monitor (
    .clk(clk), .rst_b(rst_b), .reference_clock_input(reference_clock_input), .vcoIn(vcoIn), .functionPin(functionPin),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdData(regRdData),
    .statusOut(statusOut), .statusOe(statusOe), .pumpUp(pumpUp), .pumpDown(pumpDown),
    .pumpTristate(pumpTristate), .digitalLock(digitalLock), .feedbackPulse(feedbackPulse),
    .hardResetActive(hardResetActive), .outputAlignActive(outputAlignActive),
    .powerDownActive(powerDownActive)
  );
  plm_ref_vco_model i_plm_ref_vco_model (
    .refEnable(refEnable), .refDivide(refDivide), .refDelay(refDelay),
    .reference_clock_input(reference_clock_input), .vcoIn(vcoIn)
  );
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge vcoIn) vcoCount <= vcoCount + 1;
  task automatic close_out;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    repeat (2) @(posedge clk);
    #1;
    check("regRdData", regRdData, e);
  endtask
  // 0 feedback pulse, 1 lock flag, 2 pump tristate; a lost bound ends the run
  task automatic waitSig(input int which, input logic val);
    logic s;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      #1;
      s = which == 0 ? feedbackPulse : which == 1 ? digitalLock : pumpTristate;
      if (s === val) return;
    end
    failures++;
    $display("unexpected wait %0d: expected %b seen none", which, val);
    close_out;
  endtask
  task automatic resetValues;
    rd(`PLM_REG_LOSS, 8'h00);
    rd(`PLM_REG_STAT, 8'h00);
    rd(`PLM_REG_LOCK, 8'h00);
    rd(`PLM_REG_ROLE, 8'h00);
    wr(8'h33, 8'hff);
    rd(8'h33, 8'h00);
    wr(`PLM_REG_STAT, 8'h34);
    rd(`PLM_REG_STAT, 8'h34);
  endtask
  // entries: prescaler byte, A, B, expected ratio
  task automatic divideRatios;
    logic [31:0] t [9] = '{32'h40000001, 32'h44000002, 32'h00000303,
                           32'h1c050206, 32'h08010307, 32'h0c01030d,
                           32'h10010109, 32'h14000110, 32'h18000120};
    int base;
    foreach (t[k]) begin
      wr(`PLM_REG_PRESC, t[k][31:24]);
      wr(`PLM_REG_ACNT, t[k][23:16]);
      wr(`PLM_REG_BLO, t[k][15:8]);
      wr(`PLM_REG_BHI, 8'h00);
      waitSig(0, 1'b1);
      waitSig(0, 1'b1);
      base = vcoCount;
      waitSig(0, 1'b1);
      check("ratio", 8'(vcoCount - base), t[k][7:0]);
    end
  endtask
  task automatic lockWindows;
    wr(`PLM_REG_PRESC, 8'h40);
    refEnable <= 1'b1;
    waitSig(1, 1'b1);
    rd(`PLM_REG_LOCK, 8'h80);
    refDelay <= 8'd15;
    repeat (100) @(posedge clk);
    #1;
    check("hold wide", {7'h0, digitalLock}, 8'h01);
    wr(`PLM_REG_LOCK, 8'h20);
    waitSig(1, 1'b0);
    repeat (60) @(posedge clk);
    #1;
    check("narrow off", {7'h0, digitalLock}, 8'h00);
    refDelay <= 8'd5;
    waitSig(1, 1'b1);
    wr(`PLM_REG_LOCK, 8'h03);
    refDelay <= 8'd25;
    waitSig(1, 1'b0);
    rd(`PLM_REG_LOCK, 8'h03);
    refDelay <= 8'd5;
    waitSig(1, 1'b1);
    wr(`PLM_REG_LOCK, 8'h40);
    repeat (3) @(posedge clk);
    #1;
    check("lock off", {7'h0, digitalLock}, 8'h00);
    wr(`PLM_REG_LOCK, 8'h00);
    waitSig(1, 1'b1);
  endtask
  // byte per code: selector, oe checked, expected level
  task automatic statusCodes(input logic [63:0] t, input int n);
    logic [7:0] e;
    for (int k = 0; k < n; k++) begin
      e = t[8*k +: 8];
      wr(`PLM_REG_STAT, {2'b00, e[7:4], 2'b00});
      repeat (3) @(posedge clk);
      #1;
      check("statusOut", {7'h0, statusOut}, {7'h0, e[0]});
      if (e[1]) check("statusOe", {7'h0, statusOe}, 8'h01);
    end
  endtask
  task automatic refLoss;
    wr(`PLM_REG_LOSS, 8'h64);
    repeat (100) @(posedge clk);
    rd(`PLM_REG_LOSS, 8'h64);
    repeat (150) @(posedge clk);
    rd(`PLM_REG_LOSS, 8'h6c);
    refEnable <= 1'b0;
    waitSig(2, 1'b1);
    check("pumps", {6'h0, pumpUp, pumpDown}, 8'h00);
    rd(`PLM_REG_LOSS, 8'h7c);
    statusCodes(64'h02a1f0d1e0, 5);
    wr(`PLM_REG_LOSS, 8'h60);
    repeat (2) @(posedge clk);
    #1;
    check("tristate", {7'h0, pumpTristate}, 8'h00);
    rd(`PLM_REG_LOSS, 8'h60);
    refEnable <= 1'b1;
    wr(`PLM_REG_LOSS, 8'h24);
    waitSig(1, 1'b1);
    repeat (80) @(posedge clk);
    rd(`PLM_REG_LOSS, 8'h2c);
  endtask
  task automatic pinPulse(input logic [7:0] role, input logic [7:0] exp);
    wr(`PLM_REG_ROLE, role);
    @(posedge clk);
    functionPin <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    check("roles", {5'h0, hardResetActive, outputAlignActive, powerDownActive}, exp);
    @(posedge clk);
    functionPin <= 1'b1;
    repeat (5) @(posedge clk);
  endtask
  task automatic functionRoles;
    pinPulse(8'h20, 8'h02);
    pinPulse(8'h60, 8'h01);
    pinPulse(8'h00, 8'h04);
    rd(`PLM_REG_STAT, 8'h00);
    rd(`PLM_REG_ROLE, 8'h00);
  endtask
  initial begin
    rst_b = 1'b0;
    functionPin = 1'b1;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    refEnable = 1'b0;
    refDivide = 16'h0001;
    refDelay = 8'd5;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    resetValues;
    divideRatios;
    lockWindows;
    statusCodes(64'h1332a0d0e1f150c3, 8);
    refLoss;
    functionRoles;
    close_out;
  end
endmodule // plm_monitor_tb_top
`default_nettype wire
